// file: rtl/mcs_stats.v
// Channel statistics counters with APB access and sideband statistics response.
`timescale 1ns/100ps
`include "mcs_defs.vh"

module mcs_stats (
  // Clock and reset
  input  wire        i_core_clk,
  input  wire        i_nrst,
  // APB slave
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  // LAN transmit frame events
  input  wire        i_tx_done,
  input  wire [13:0] i_tx_len,
  input  wire        i_tx_good,
  input  wire        i_tx_filt,
  // LAN receive frame events
  input  wire        i_rx_done,
  input  wire [13:0] i_rx_len,
  input  wire        i_rx_err,
  input  wire        i_rx_fcs_bad,
  // Sideband control packet events
  input  wire        i_sb_rx,
  input  wire        i_sb_fcs_ok,
  input  wire        i_sb_drop,
  input  wire        i_sb_csum_bad,
  input  wire        i_sb_csum_present,
  input  wire        i_sb_unsup,
  input  wire        i_sb_pkg,
  input  wire [7:0]  i_sb_cmd,
  input  wire        i_sb_rsp_sent,
  input  wire        i_sb_aen_sent,
  // Sideband statistics response
  input  wire        i_rsp_ready,
  output reg         o_rsp_valid,
  output reg  [7:0]  o_rsp_code,
  output reg  [2:0]  o_rsp_idx,
  output reg  [31:0] o_rsp_word,
  output reg         o_rsp_last
);

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  reg  [`MCS_CTRL_W-1:0] ctrl;
  reg  [13:0]            mtu;
  wire [31:0]             clr_lo;
  wire [`MCS_HI_USED-1:0] clr_hi;
  wire [`MCS_LAN_N-1:0]   clr_flag;

  // A request is decoded in its setup cycle; a write takes effect at the edge
  // that completes its access phase, which is the edge where ready is high.
  wire apb_setup = i_psel && !i_penable;
  wire apb_acc   = i_psel && i_penable;
  wire apb_wr    = apb_acc && i_pwrite && o_pready;
  wire wr_ctrl   = apb_wr && (i_paddr == `MCS_A_CTRL);
  wire wr_mtu    = apb_wr && (i_paddr == `MCS_A_MTU);
  wire wr_sbread = apb_wr && (i_paddr == `MCS_A_SB_READ);

  // Host clear strobes: one bit per LAN counter, one for all sideband counters.
  wire [`MCS_LAN_N-1:0] host_clr;
  wire                  sb_clr_all = wr_ctrl && i_pwdata[`MCS_CTRL_SBCLR];

  // Response sequencer states; the sequencer is busy while a response streams.
  localparam [1:0] RSP_IDLE = 2'b01;
  localparam [1:0] RSP_SEND = 2'b10;
  reg  [1:0] rsp_state;
  reg  [1:0] next_rsp_state;
  reg  [2:0] rsp_cnt;
  wire       rsp_busy = (rsp_state == RSP_SEND);
  wire       rsp_take = o_rsp_valid && i_rsp_ready;

  // A statistics request freezes a copy of the sideband counters and counts as a sideband read,
  // which clears the cleared-since-read flags.
  wire rsp_start = i_sb_rx && !i_sb_drop && (i_sb_cmd == `MCS_CMD_STATS) && !rsp_busy;
  wire sb_read   = rsp_start || wr_sbread;

  // --------------------------------------------------------------------------
  // LAN event qualification
  // --------------------------------------------------------------------------
  reg [`MCS_LAN_N-1:0] lan_inc;
  always @* begin
    lan_inc = {`MCS_LAN_N{1'b0}};
    if (i_tx_done && i_tx_good) begin
      lan_inc[`MCS_C_TX64]   = (i_tx_len == `MCS_LEN_64);
      lan_inc[`MCS_C_TX64+1] = (i_tx_len > `MCS_LEN_64)  && (i_tx_len <= `MCS_LEN_127);
      lan_inc[`MCS_C_TX64+2] = (i_tx_len > `MCS_LEN_127) && (i_tx_len <= `MCS_LEN_255);
      lan_inc[`MCS_C_TX64+3] = (i_tx_len > `MCS_LEN_255) && (i_tx_len <= `MCS_LEN_511);
      lan_inc[`MCS_C_TX64+4] = (i_tx_len > `MCS_LEN_511) && (i_tx_len <= `MCS_LEN_1023);
      lan_inc[`MCS_C_TX64+5] = (i_tx_len > `MCS_LEN_1023) && (i_tx_len <= `MCS_LEN_1522);
    end
    // The last bin ends at 1522 and oversize starts above 1523, so a frame of exactly 1523 bytes
    // lands in no bin and is not oversize either.
    lan_inc[`MCS_C_TXOV] = i_tx_done && i_tx_filt && (i_tx_len > `MCS_LEN_1523);
    lan_inc[`MCS_C_VBYTES] = i_rx_done && !i_rx_err && !i_rx_fcs_bad;
    lan_inc[`MCS_C_RUNT] = i_rx_done && i_rx_err && (i_rx_len < `MCS_LEN_64);
    lan_inc[`MCS_C_JAB] = i_rx_done && i_rx_fcs_bad && (i_rx_len > mtu);
  end

  // --------------------------------------------------------------------------
  // LAN counters 29 through 38
  // --------------------------------------------------------------------------
  wire [31:0] lan_val [0:`MCS_LAN_N-1];
  genvar g;
  generate
    for (g = 0; g < `MCS_LAN_N; g = g + 1) begin : g_lan
      assign host_clr[g] = apb_wr && (i_paddr == (`MCS_A_LAN_BASE + `MCS_A_STEP * g));
      mcs_counter u_cnt (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_clr      (host_clr[g]),
        .i_inc      (lan_inc[g]),
        .i_amount   ((g == `MCS_C_VBYTES) ? {18'h00000, i_rx_len} : 32'h0000_0001),
        .o_value    (lan_val[g])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Cleared-since-last-read flags
  // --------------------------------------------------------------------------
  // One flag per LAN counter: a host clear raises it, a sideband read drops
  // it. A clear in the same cycle as the read still raises its flag, so no
  // clear slips past the controller unseen.
  generate
    for (g = 0; g < `MCS_LAN_N; g = g + 1) begin : g_flag
      reg flag;
      always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          flag <= 1'b0;
        end else if (host_clr[g]) begin
          flag <= 1'b1;
        end else if (sb_read) begin
          flag <= 1'b0;
        end
      end
      assign clr_flag[g] = flag;
    end
  endgenerate

  // Flags for counters 29-31 fill the top of the low word, 32-38 the high
  // word; counters 0-28 are not held here and their flags read zero.
  assign clr_lo = {clr_flag[`MCS_LO_FLAGS-1:0], {`MCS_LAN_BASE{1'b0}}};
  assign clr_hi = clr_flag[`MCS_LAN_N-1:`MCS_LO_FLAGS];

  // --------------------------------------------------------------------------
  // Sideband counters
  // --------------------------------------------------------------------------
  wire sb_count_ok = !i_sb_pkg || ctrl[`MCS_CTRL_PKG];
  wire sb_good = i_sb_rx && i_sb_fcs_ok && sb_count_ok;
  wire [`MCS_SB_N-1:0] sb_inc;
  assign sb_inc[`MCS_S_CMD]   = sb_good && !i_sb_drop;
  assign sb_inc[`MCS_S_DROP]  = sb_good && i_sb_drop;
  assign sb_inc[`MCS_S_TYPE]  = sb_good && !i_sb_drop && i_sb_unsup;
  assign sb_inc[`MCS_S_CSUM]  = sb_good && i_sb_drop && i_sb_csum_bad && i_sb_csum_present
                                && ctrl[`MCS_CTRL_CSUM];
  assign sb_inc[`MCS_S_RXTOT] = 1'b0;
  assign sb_inc[`MCS_S_TXTOT] = 1'b0;
  assign sb_inc[`MCS_S_AEN]   = i_sb_aen_sent;

  wire [31:0] sb_val [0:`MCS_SB_N-1];
  // Responses sent are counted here; the transmit total adds the event count.
  reg  [31:0] rsp_cnt_tx;
  generate
    for (g = 0; g < `MCS_SB_N; g = g + 1) begin : g_sb
      if (g == `MCS_S_RXTOT) begin : g_rx
        assign sb_val[g] = sb_val[`MCS_S_CMD] + sb_val[`MCS_S_DROP];
      end else if (g == `MCS_S_TXTOT) begin : g_tx
        assign sb_val[g] = rsp_cnt_tx + sb_val[`MCS_S_AEN];
      end else begin : g_cnt
        mcs_counter u_cnt (
          .i_core_clk (i_core_clk),
          .i_nrst     (i_nrst),
          .i_clr      (sb_clr_all),
          .i_inc      (sb_inc[g]),
          .i_amount   (32'h0000_0001),
          .o_value    (sb_val[g])
        );
      end
    end
  endgenerate

  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rsp_cnt_tx <= 32'h0000_0000;
    end else if (sb_clr_all) begin
      rsp_cnt_tx <= i_sb_rsp_sent ? 32'h0000_0001 : 32'h0000_0000;
    end else if (i_sb_rsp_sent) begin
      rsp_cnt_tx <= rsp_cnt_tx + 32'h0000_0001;
    end
  end

  // --------------------------------------------------------------------------
  // Statistics response stream
  // --------------------------------------------------------------------------
  // Seven words are frozen at the request and sent in order; header, codes
  // and checksum are built by the packet engine around them.
  // The sequencer leaves SEND only once the last word has been taken, so a
  // second request cannot tear a response that is still streaming.
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rsp_state <= RSP_IDLE;
    end else begin
      rsp_state <= next_rsp_state;
    end
  end

  always @* begin
    next_rsp_state = rsp_state;
    case (rsp_state)
      RSP_IDLE: begin
        if (rsp_start) begin
          next_rsp_state = RSP_SEND;
        end
      end
      RSP_SEND: begin
        if (rsp_take && o_rsp_last) begin
          next_rsp_state = RSP_IDLE;
        end
      end
      default: begin
        next_rsp_state = RSP_IDLE;
      end
    endcase
  end

  reg [31:0] snap [0:`MCS_SB_N-1];
  integer k;
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rsp_cnt     <= 3'h0;
      o_rsp_valid <= 1'b0;
      o_rsp_code  <= 8'h00;
      o_rsp_idx   <= 3'h0;
      o_rsp_word  <= 32'h0000_0000;
      o_rsp_last  <= 1'b0;
      for (k = 0; k < `MCS_SB_N; k = k + 1) begin
        snap[k] <= 32'h0000_0000;
      end
    end else if (rsp_start) begin
      for (k = 0; k < `MCS_SB_N; k = k + 1) begin
        snap[k] <= sb_val[k];
      end
      rsp_cnt     <= 3'h1;
      o_rsp_valid <= 1'b1;
      o_rsp_code  <= `MCS_RSP_STATS;
      o_rsp_idx   <= 3'h0;
      o_rsp_word  <= sb_val[0];
      o_rsp_last  <= 1'b0;
    end else if (rsp_take) begin
      if (o_rsp_last) begin
        o_rsp_valid <= 1'b0;
        o_rsp_last  <= 1'b0;
      end else begin
        o_rsp_idx  <= rsp_cnt;
        o_rsp_word <= snap[rsp_cnt];
        o_rsp_last <= (rsp_cnt == `MCS_SB_LAST);
        rsp_cnt    <= rsp_cnt + 3'h1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------------
  // Reads are decoded in the setup cycle and held in o_prdata for the access.
  reg [31:0] rd_mux;
  reg        rd_ok;
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_ok  = 1'b1;
    if (i_paddr >= `MCS_A_LAN_BASE && i_paddr <= `MCS_A_LAN_LAST && i_paddr[1:0] == 2'b00) begin
      rd_mux = lan_val[i_paddr[5:2]];
    end else if (i_paddr >= `MCS_A_SB_BASE && i_paddr <= `MCS_A_SB_LAST && i_paddr[1:0] == 2'b00) begin
      rd_mux = sb_val[i_paddr[4:2]];
    end else begin
      case (i_paddr)
        `MCS_A_CTRL: begin
          rd_mux = {29'h0000_0000, ctrl};
        end
        `MCS_A_CLR_LO: begin
          rd_mux = clr_lo;
        end
        `MCS_A_CLR_HI: begin
          rd_mux = {25'h000_0000, clr_hi};
        end
        `MCS_A_SB_READ: begin
          rd_mux = 32'h0000_0000;
        end
        `MCS_A_STATUS: begin
          rd_mux = {31'h0000_0000, rsp_busy};
        end
        `MCS_A_MTU: begin
          rd_mux = {18'h00000, mtu};
        end
        default: begin
          rd_ok  = 1'b0;
        end
      endcase
    end
  end

  // Ready and error answer in the first access cycle, so every transfer
  // completes without wait states.
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_prdata  <= 32'h0000_0000;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= apb_setup;
      o_pslverr <= apb_setup && !rd_ok;
      if (apb_setup && !i_pwrite) begin
        o_prdata <= rd_mux;
      end
    end
  end

  // The PFC bit only tells the pause counters, which sit outside this block,
  // whether priority frames count as pause frames.
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl <= `MCS_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= i_pwdata[`MCS_CTRL_W-1:0];
    end
  end

  // Jabber limit: longer frames with a bad FCS are counted as jabbers.
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mtu <= `MCS_MTU_RST;
    end else if (wr_mtu) begin
      mtu <= i_pwdata[`MCS_MTU_W-1:0];
    end
  end

endmodule // mcs_stats

// file: rtl/mcs_defs.vh
// Constants for the management channel statistics block.
`ifndef MCS_DEFS_VH
`define MCS_DEFS_VH

// ----------------------------------------------------------------------------
// APB register map (byte addresses)
// ----------------------------------------------------------------------------
`define MCS_A_CTRL      12'h000
`define MCS_A_CLR_LO    12'h004
`define MCS_A_CLR_HI    12'h008
`define MCS_A_SB_READ   12'h00C
`define MCS_A_STATUS    12'h010
`define MCS_A_MTU       12'h014
`define MCS_A_LAN_BASE  12'h100
`define MCS_A_LAN_LAST  12'h128
`define MCS_A_SB_BASE   12'h200
`define MCS_A_SB_LAST   12'h218
`define MCS_A_STEP      12'h004

// ----------------------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------------------
`define MCS_CTRL_PKG    0
`define MCS_CTRL_PFC    1
`define MCS_CTRL_CSUM   2
`define MCS_CTRL_W      3
`define MCS_CTRL_RST    3'h4
`define MCS_MTU_RST     14'h05EE
`define MCS_HI_USED     7
`define MCS_CTRL_SBCLR  31
`define MCS_MTU_W       14
`define MCS_LO_FLAGS    3

// ----------------------------------------------------------------------------
// Frame length bounds and codes
// ----------------------------------------------------------------------------
`define MCS_LEN_64      14'h0040
`define MCS_LEN_127     14'h007F
`define MCS_LEN_255     14'h00FF
`define MCS_LEN_511     14'h01FF
`define MCS_LEN_1023    14'h03FF
`define MCS_LEN_1522    14'h05F2
`define MCS_LEN_1523    14'h05F3
`define MCS_CMD_STATS   8'h19
`define MCS_RSP_STATS   8'h99

// ----------------------------------------------------------------------------
// Counter indices
// ----------------------------------------------------------------------------
`define MCS_LAN_N       10
`define MCS_LAN_BASE    29
`define MCS_C_TX64      0
`define MCS_C_TXOV      6
`define MCS_C_VBYTES    7
`define MCS_C_RUNT      8
`define MCS_C_JAB       9
`define MCS_SB_N        7
`define MCS_S_CMD       0
`define MCS_S_DROP      1
`define MCS_S_TYPE      2
`define MCS_S_CSUM      3
`define MCS_S_RXTOT     4
`define MCS_S_TXTOT     5
`define MCS_S_AEN       6
`define MCS_SB_LAST     3'h6

`endif

// file: rtl/mcs_counter.v
// One 32-bit statistics counter with clear and increment.
`timescale 1ns/100ps

module mcs_counter (
  // Clock and reset
  input  wire        i_core_clk,
  input  wire        i_nrst,
  // Control
  input  wire        i_clr,
  input  wire        i_inc,
  input  wire [31:0] i_amount,
  // Value
  output reg  [31:0] o_value
);

  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_value <= 32'h0000_0000;
    end else if (i_clr) begin
      o_value <= i_inc ? i_amount : 32'h0000_0000;
    end else if (i_inc) begin
      o_value <= o_value + i_amount;
    end
  end

endmodule // mcs_counter

// file: dv/mcs_stats_checker.sv
// Port assertions for the channel statistics block.
`timescale 1ns/100ps
module mcs_stats_checker (
  // Clock, reset and APB
  input logic        i_core_clk,
  input logic        i_nrst,
  input logic        i_psel,
  input logic        i_penable,
  input logic [11:0] i_paddr,
  input logic        o_pready,
  input logic        o_pslverr,
  // Sideband
  input logic        i_sb_rx,
  input logic        i_sb_drop,
  input logic [7:0]  i_sb_cmd,
  input logic        i_rsp_ready,
  input logic        o_rsp_valid,
  input logic [7:0]  o_rsp_code,
  input logic [2:0]  o_rsp_idx,
  input logic [31:0] o_rsp_word,
  input logic        o_rsp_last
);
  // ----------
  // Checks
  // ----------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  apb_ready_a: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  unmapped_err_a: assert property (i_psel && !i_penable && i_paddr == 12'hFFC |=> o_pslverr)
    else $error("no error on unmapped address");
  stats_start_a: assert property (i_sb_rx && !i_sb_drop && i_sb_cmd == 8'h19 && !o_rsp_valid |=> o_rsp_valid && o_rsp_idx == 3'h0)
    else $error("statistics request not answered");
  rsp_code_a: assert property (o_rsp_valid |-> o_rsp_code == 8'h99)
    else $error("wrong response code");
  rsp_hold_a: assert property (o_rsp_valid && !i_rsp_ready |=> o_rsp_valid && $stable(o_rsp_word) && $stable(o_rsp_idx))
    else $error("response word changed while stalled");
  rsp_step_a: assert property (o_rsp_valid && i_rsp_ready && !o_rsp_last |=> o_rsp_valid && o_rsp_idx == $past(o_rsp_idx) + 3'h1)
    else $error("response index did not advance");
  rsp_last_a: assert property (o_rsp_valid |-> o_rsp_last == (o_rsp_idx == 3'h6))
    else $error("last flag not on seventh word");
  rsp_end_a: assert property (o_rsp_valid && i_rsp_ready && o_rsp_last |=> !o_rsp_valid)
    else $error("valid stayed after last word");
endmodule // mcs_stats_checker

// file: dv/mcs_mgmt_model.sv
// Management controller model on the sideband side of the statistics block.
`timescale 1ns/100ps
module mcs_mgmt_model (
  // Clock and reset
  input  logic        i_core_clk,
  input  logic        i_nrst,
  input  logic        i_slow,
  // Packet events; flags are fcs_ok, drop, csum_bad, csum_present, unsup, pkg
  output logic        o_sb_rx,
  output logic [5:0]  o_sb_flags,
  output logic [7:0]  o_sb_cmd,
  // Statistics response
  input  logic        i_rsp_valid,
  input  logic [2:0]  i_rsp_idx,
  input  logic [31:0] i_rsp_word,
  input  logic        i_rsp_last,
  output logic        o_rsp_ready
);
  logic [31:0] words [0:6];
  logic [3:0]  n_rsp;
  initial begin
    o_sb_rx = 1'b0;
    o_sb_flags = 6'h00;
    o_sb_cmd = 8'h00;
  end
  // Qualifiers are scrambled between packets since they mean nothing then.
  task automatic send(input logic [5:0] f, input logic [7:0] c);
    @(posedge i_core_clk);
    o_sb_rx <= 1'b1;
    o_sb_flags <= f;
    o_sb_cmd <= c;
    @(posedge i_core_clk);
    o_sb_rx <= 1'b0;
    o_sb_flags <= ~f;
    o_sb_cmd <= ~c;
  endtask
  // A slow controller takes a word only every other cycle.
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rsp_ready <= 1'b0;
      n_rsp <= 4'h0;
    end else begin
      o_rsp_ready <= i_slow ? ~o_rsp_ready : 1'b1;
      if (i_rsp_valid && o_rsp_ready) begin
        words[i_rsp_idx] <= i_rsp_word;
        if (i_rsp_last) n_rsp <= n_rsp + 4'h1;
      end
    end
  end
endmodule // mcs_mgmt_model

// file: dv/test_mcs_stats.sv
// Self-checking bench for the channel statistics block.
`timescale 1ns/100ps
module test_mcs_stats;
  logic        i_core_clk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        psel = 0, pen = 0, pwr = 0, txd = 0, txg = 0, txf = 0, rxd = 0, rxe = 0, rxb = 0;
  logic        rsps = 0, aens = 0, slow = 0, pready, pslverr, err, sbrx, ready, rv, rl;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rw;
  logic [13:0] txl = 14'h0000, rxl = 14'h0000;
  logic [5:0]  sbf;
  logic [7:0]  sbc, rc;
  logic [2:0]  ri;
  int          miscompares = 0;
  int          checked = 0;

  always #10 i_core_clk = ~i_core_clk;

  mcs_stats dut (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_tx_done(txd), .i_tx_len(txl), .i_tx_good(txg), .i_tx_filt(txf),
    .i_rx_done(rxd), .i_rx_len(rxl), .i_rx_err(rxe), .i_rx_fcs_bad(rxb),
    .i_sb_rx(sbrx), .i_sb_fcs_ok(sbf[5]), .i_sb_drop(sbf[4]), .i_sb_csum_bad(sbf[3]),
    .i_sb_csum_present(sbf[2]), .i_sb_unsup(sbf[1]), .i_sb_pkg(sbf[0]), .i_sb_cmd(sbc),
    .i_sb_rsp_sent(rsps), .i_sb_aen_sent(aens), .i_rsp_ready(ready), .o_rsp_valid(rv),
    .o_rsp_code(rc), .o_rsp_idx(ri), .o_rsp_word(rw), .o_rsp_last(rl));

  mcs_mgmt_model u_mc (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_slow(slow), .o_sb_rx(sbrx), .o_sb_flags(sbf),
    .o_sb_cmd(sbc), .i_rsp_valid(rv), .i_rsp_idx(ri), .i_rsp_word(rw), .i_rsp_last(rl), .o_rsp_ready(ready));

  // ----------
  // Bus and event tasks
  // ----------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge i_core_clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_core_clk);
    pen <= 1'b1;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) miscompares++;
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic tx(input int l, input logic g, input logic f);
    @(posedge i_core_clk);
    txd <= 1'b1;
    txl <= l[13:0];
    txg <= g;
    txf <= f;
    @(posedge i_core_clk);
    txd <= 1'b0;
  endtask

  task automatic rx(input int l, input logic e, input logic b);
    @(posedge i_core_clk);
    rxd <= 1'b1;
    rxl <= l[13:0];
    rxe <= e;
    rxb <= b;
    @(posedge i_core_clk);
    rxd <= 1'b0;
  endtask

  task automatic txev(input logic r, input logic a);
    @(posedge i_core_clk);
    rsps <= r;
    aens <= a;
    @(posedge i_core_clk);
    rsps <= 1'b0;
    aens <= 1'b0;
  endtask

  // ----------
  // Scenarios
  // ----------
  task automatic t_reset;
    rd(12'h000, 32'h4);
    rd(12'h014, 32'h5EE);
    rd(12'h004, 32'h0);
    rd(12'h008, 32'h0);
    rd(12'h010, 32'h0);
    for (int i = 0; i < 10; i++) rd(12'h100 + 12'(4 * i), 32'h0);
    for (int i = 0; i < 7; i++) rd(12'h200 + 12'(4 * i), 32'h0);
  endtask

  task automatic t_unmapped;
    logic [31:0] r;
    apb(1'b1, 12'hFFC, 32'h1, r);
    chk(32'(err), 32'h1);
    apb(1'b0, 12'hFFC, 32'h0, r);
    chk(32'(err), 32'h1);
  endtask

  task automatic t_tx;
    int lens [13] = '{64, 65, 127, 128, 255, 256, 511, 512, 1023, 1024, 1522, 1523, 63};
    foreach (lens[i]) tx(lens[i], 1'b1, 1'b1);
    tx(64, 1'b0, 1'b1);
    tx(1524, 1'b0, 1'b1);
    tx(9000, 1'b1, 1'b0);
    for (int i = 0; i < 6; i++) rd(12'h100 + 12'(4 * i), (i == 0) ? 32'h1 : 32'h2);
    rd(12'h118, 32'h1);
  endtask

  task automatic t_rx;
    rx(100, 1'b0, 1'b0);
    rx(63, 1'b1, 1'b0);
    rx(1600, 1'b1, 1'b1);
    rx(1600, 1'b1, 1'b0);
    rx(3000, 1'b1, 1'b1);
    rx(200, 1'b0, 1'b0);
    rd(12'h11C, 32'h12C);
    rd(12'h120, 32'h1);
    rd(12'h124, 32'h2);
    wr(12'h014, 32'hBB8);
    rd(12'h014, 32'hBB8);
    rx(2000, 1'b1, 1'b1);
    rx(3001, 1'b1, 1'b1);
    rd(12'h124, 32'h3);
  endtask

  task automatic t_clear;
    wr(12'h100, 32'h0);
    wr(12'h124, 32'h0);
    rd(12'h100, 32'h0);
    rd(12'h004, 32'h2000_0000);
    rd(12'h008, 32'h40);
    wr(12'h00C, 32'h0);
    rd(12'h004, 32'h0);
    tx(64, 1'b1, 1'b1);
    rd(12'h100, 32'h1);
  endtask

  task automatic t_sb;
    int n;
    u_mc.send(6'b100000, 8'h05);
    u_mc.send(6'b100010, 8'h50);
    u_mc.send(6'b111100, 8'h05);
    u_mc.send(6'b111000, 8'h05);
    u_mc.send(6'b010000, 8'h05);
    u_mc.send(6'b100001, 8'h05);
    wr(12'h000, 32'h7);
    rd(12'h000, 32'h7);
    u_mc.send(6'b100001, 8'h05);
    txev(1'b1, 1'b0);
    txev(1'b1, 1'b0);
    txev(1'b0, 1'b1);
    rd(12'h200, 32'h3);
    slow <= 1'b1;
    u_mc.send(6'b100000, 8'h19);
    n = 0;
    while (u_mc.n_rsp !== 4'h1 && n < 100) begin
      @(posedge i_core_clk);
      n++;
    end
    if (u_mc.n_rsp !== 4'h1) miscompares++;
    chk(u_mc.words[1], 32'h2);
    chk(u_mc.words[2], 32'h1);
    chk(u_mc.words[3], 32'h1);
    chk(u_mc.words[4] - u_mc.words[0], 32'h2);
    chk(u_mc.words[5], 32'h3);
    chk(u_mc.words[6], 32'h1);
    chk(32'(u_mc.words[0] inside {32'h3, 32'h4}), 32'h1);
    rd(12'h210, 32'h6);
    rd(12'h010, 32'h0);
    wr(12'h000, 32'h8000_0007);
    rd(12'h200, 32'h0);
    rd(12'h214, 32'h0);
    txev(1'b1, 1'b1);
    rd(12'h214, 32'h2);
  endtask

  task automatic finish_test;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // The tests need about 260 cycles; the watchdog allows 20000.
  initial begin
    #400000;
    miscompares++;
    finish_test;
  end

  initial begin
    repeat (10) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    t_reset;
    t_unmapped;
    t_tx;
    t_rx;
    t_clear;
    t_sb;
    finish_test;
  end
endmodule // test_mcs_stats

bind mcs_stats mcs_stats_checker u_chk (
  .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_psel(i_psel), .i_penable(i_penable), .i_paddr(i_paddr),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_sb_rx(i_sb_rx), .i_sb_drop(i_sb_drop), .i_sb_cmd(i_sb_cmd),
  .i_rsp_ready(i_rsp_ready), .o_rsp_valid(o_rsp_valid), .o_rsp_code(o_rsp_code), .o_rsp_idx(o_rsp_idx),
  .o_rsp_word(o_rsp_word), .o_rsp_last(o_rsp_last));
